// ==== hdl_pkg.sv ====
// Shared constants and types of the historical data logger.
// Assumes one 100 MHz clock and a same-domain real-time clock source.
package hdl_pkg;

  // ------------------------------------------------------------
  // Sizes and limits
  // ------------------------------------------------------------
  localparam int NLOG = 3;
  localparam int POOL_SECT = 63;
  localparam int MAX_PARAM = 117;
  localparam int MAX_IVL = 1444;
  localparam int SECT_BYTES = 65536;
  localparam int MAX_DATA = 234;
  localparam int WIN_BYTES = 246;
  localparam int STAMP_BYTES = 4;
  localparam int AW = 8;
  localparam int DW = 32;

  // ------------------------------------------------------------
  // Register map: per-log word index is log*8 + field index
  // ------------------------------------------------------------
  localparam logic [2:0] R_IVL = 3'h0;
  localparam logic [2:0] R_SECT = 3'h1;
  localparam logic [2:0] R_DATA = 3'h2;
  localparam logic [2:0] R_PARAM = 3'h3;
  localparam logic [2:0] R_TIMER = 3'h4;
  localparam logic [2:0] R_STAT = 3'h5;
  localparam logic [2:0] R_FIRST = 3'h6;
  localparam logic [AW-1:0] R_WCTRL = 8'h18;
  localparam logic [AW-1:0] R_WSTART = 8'h19;
  localparam logic [AW-1:0] R_WCNT = 8'h1a;
  localparam logic [AW-1:0] R_ERR = 8'h1b;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int TMR_EN = 0;
  localparam int TMR_START = 1;
  localparam int TMR_END = 12;
  localparam int WC_OFS = 2;
  localparam int ST_WR = 20;
  localparam int ST_STOP = 31;
  localparam int WCNT_BUSY = 8;
  localparam int WCNT_RNG = 9;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [10:0] IVL_RST = 11'h000;
  localparam logic [5:0] SECT_RST = 6'h00;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [6:0] PARAM_RST = 7'h00;
  localparam logic [10:0] MIN_RST = 11'h000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
  } hdl_bus_s;

  typedef struct packed {
    logic req;
    logic erase;
    logic [1:0] log;
    logic [5:0] sector;
    logic [15:0] offset;
    logic [31:0] stamp;
  } hdl_flash_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PLACE = 2'b01,
    ST_ERASE = 2'b10,
    ST_WRITE = 2'b11
  } hdl_state_e;

endpackage

// ==== hdl_div.sv ====
// Iterative restoring divider, one quotient bit per clock.
// Assumes the caller holds no new start while busy.
`timescale 1ns/1ps
`default_nettype none
module hdl_div #(
  parameter int W = 8
) (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic [W-1:0] i_num,
  input wire logic [W-1:0] i_den,
  output logic o_done,
  output logic [W-1:0] o_quo
);

  if (W < 2) $error("hdl_div width too small");

  logic [W-1:0] rem_r, rem_nxt, quo_r, quo_nxt, den_r, den_nxt;
  logic [$clog2(W+1)-1:0] cnt_r, cnt_nxt;
  logic done_r, done_nxt;
  logic [W:0] trial;

  always_comb
  begin
    rem_nxt = rem_r;
    quo_nxt = quo_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    trial = {rem_r, quo_r[W-1]} - {1'b0, den_r};
    if (i_start)
    begin
      rem_nxt = '0;
      quo_nxt = i_num;
      den_nxt = i_den;
      cnt_nxt = ($clog2(W+1))'(W);
    end
    else if (cnt_r != '0)
    begin
      if (!trial[W])
      begin
        rem_nxt = trial[W-1:0];
        quo_nxt = {quo_r[W-2:0], 1'b1};
      end
      else
      begin
        rem_nxt = {rem_r[W-2:0], quo_r[W-1]};
        quo_nxt = {quo_r[W-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - 1'b1;
      done_nxt = (cnt_r == 1);
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      rem_r <= '0;
      quo_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      rem_r <= rem_nxt;
      quo_r <= quo_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign o_done = done_r;
  assign o_quo = quo_r;

endmodule
`default_nettype wire

// ==== hdl_logger.sv ====
// Three-log historical data logger: timers, sector pool, window reads.
// Assumes minute tick, time of day and stamp come from the same clock.
// Function
// (RL1) Three logs, each with its own parameters, interval and sectors.
// (RL2) At most 117 parameters per log are accepted.
// (RL3) Logs share 63 sectors; allocations summing above 63 are refused.
// (RL4) Interval in minutes, programmable from 0 to 1444.
// (RL5) One snapshot each time a log's interval elapses.
// (RL6) Interval zero disables the log; no snapshots.
// (RL7) With timer enabled, snapshots only between start and end time.
// (RL8) Timer enabled and full: stop logging, erase nothing.
// (RL9) Timer disabled and full: erase oldest sector, next becomes first.
// (RL10) Sectors are 65536 bytes; erase frees exactly one sector.
// (RL11) Record parameter data limited to 234 bytes.
// (RL12) Window record count is 246 divided by record size.
// (RL13) Log type code 0, 1, 2 selects first, second, third log.
// (RL14) Window starts at requested offset from the log's first record.
// (RL15) Host advances offset window by window to read everything.
// (RL16) Each record gets the real-time stamp when created.
// (RL17) Pointers wrap only inside the log's own sectors.
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hdl_logger
  import hdl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire hdl_bus_s i_bus,
  output logic [DW-1:0] o_rdata,
  input wire logic i_minute_tick,
  input wire logic [10:0] i_day_minute,
  input wire logic [31:0] i_rtc_stamp,
  output hdl_flash_s o_flash,
  input wire logic i_flash_ack
);

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [10:0] ivl_r [NLOG], ivl_nxt [NLOG];
  logic [5:0] sect_r [NLOG], sect_nxt [NLOG];
  logic [7:0] data_r [NLOG], data_nxt [NLOG];
  logic [6:0] param_r [NLOG], param_nxt [NLOG];
  logic [10:0] start_r [NLOG], start_nxt [NLOG], end_r [NLOG], end_nxt [NLOG];
  logic [NLOG-1:0] tmr_r, tmr_nxt;
  logic err_r, err_nxt, realloc;
  logic [1:0] wl;
  logic [2:0] wf;
  logic [7:0] sum_try;
  logic [5:0] base [NLOG];
  hdl_state_e state_r, state_nxt;

  assign wl = i_bus.addr[4:3];
  assign wf = i_bus.addr[2:0];

  always_comb
  begin
    base[0] = 6'h00;
    base[1] = sect_r[0];
    base[2] = 6'(sect_r[0] + sect_r[1]);
  end

  always_comb
  begin
    ivl_nxt = ivl_r;
    sect_nxt = sect_r;
    data_nxt = data_r;
    param_nxt = param_r;
    start_nxt = start_r;
    end_nxt = end_r;
    tmr_nxt = tmr_r;
    err_nxt = err_r;
    realloc = 1'b0;
    sum_try = 8'(sect_r[0]) + 8'(sect_r[1]) + 8'(sect_r[2]) - 8'(sect_r[wl])
      + 8'(i_bus.wdata[5:0]);
    if (i_bus.wr && i_bus.addr < R_WCTRL && wl != 2'd3)
    begin
      case (wf)
        R_IVL: ivl_nxt[wl] = (i_bus.wdata > MAX_IVL) ? 11'(MAX_IVL) : i_bus.wdata[10:0]; // RL4
        R_SECT:
        begin
          if (i_bus.wdata[31:6] != '0 || sum_try > 8'(POOL_SECT) || state_r != ST_IDLE)
            err_nxt = 1'b1; // RL3
          else
          begin
            sect_nxt[wl] = i_bus.wdata[5:0]; // RL1
            realloc = 1'b1;
          end
        end
        R_DATA: data_nxt[wl] = (i_bus.wdata > MAX_DATA) ? 8'(MAX_DATA) : i_bus.wdata[7:0]; // RL11
        R_PARAM: param_nxt[wl] = (i_bus.wdata > MAX_PARAM) ? 7'(MAX_PARAM) : i_bus.wdata[6:0]; // RL2
        R_TIMER:
        begin
          tmr_nxt[wl] = i_bus.wdata[TMR_EN];
          start_nxt[wl] = i_bus.wdata[TMR_START +: 11];
          end_nxt[wl] = i_bus.wdata[TMR_END +: 11];
        end
        default: ;
      endcase
    end
    if (i_bus.wr && i_bus.addr == R_ERR)
      err_nxt = 1'b0;
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < NLOG; i++)
      begin
        ivl_r[i] <= IVL_RST;
        sect_r[i] <= SECT_RST;
        data_r[i] <= DATA_RST;
        param_r[i] <= PARAM_RST;
        start_r[i] <= MIN_RST;
        end_r[i] <= MIN_RST;
      end
      tmr_r <= '0;
      err_r <= 1'b0;
    end
    else
    begin
      ivl_r <= ivl_nxt;
      sect_r <= sect_nxt;
      data_r <= data_nxt;
      param_r <= param_nxt;
      start_r <= start_nxt;
      end_r <= end_nxt;
      tmr_r <= tmr_nxt;
      err_r <= err_nxt;
    end
  end

  // ------------------------------------------------------------
  // Interval timers, one per log
  // ------------------------------------------------------------
  logic [NLOG-1:0] tick_v;

  for (genvar g = 0; g < NLOG; g++)
  begin : g_tmr
    logic [10:0] cnt_r, cnt_nxt;
    logic in_win, tick_l;
    always_comb
    begin
      if (start_r[g] <= end_r[g])
        in_win = i_day_minute >= start_r[g] && i_day_minute < end_r[g];
      else
        in_win = i_day_minute >= start_r[g] || i_day_minute < end_r[g];
      cnt_nxt = cnt_r;
      tick_l = 1'b0;
      if (ivl_r[g] == '0)
        cnt_nxt = '0; // RL6
      else if (i_minute_tick)
      begin
        if (cnt_r + 11'd1 >= ivl_r[g])
        begin
          cnt_nxt = '0;
          tick_l = !tmr_r[g] || in_win; // RL5 RL7
        end
        else
          cnt_nxt = cnt_r + 11'd1;
      end
    end
    always_ff @(posedge i_clock or posedge i_reset)
    begin
      if (i_reset)
        cnt_r <= '0;
      else
        cnt_r <= cnt_nxt;
    end
    assign tick_v[g] = tick_l;
  end

  // ------------------------------------------------------------
  // Storage engine: places records and recycles sectors
  // ------------------------------------------------------------
  logic [5:0] wsec_r [NLOG], wsec_nxt [NLOG], first_r [NLOG], first_nxt [NLOG];
  logic [16:0] ofs_r [NLOG], ofs_nxt [NLOG];
  logic [19:0] stored_r [NLOG], stored_nxt [NLOG];
  logic [31:0] fseq_r [NLOG], fseq_nxt [NLOG];
  logic [14:0] scnt_r [POOL_SECT], scnt_nxt [POOL_SECT];
  logic [NLOG-1:0] stop_r, stop_nxt, pend_r, pend_nxt, en_v, take;
  logic [1:0] cur_r, cur_nxt;
  hdl_flash_s flash_r, flash_nxt;
  logic [8:0] rsize;
  logic fit;
  logic [5:0] nsec, wabs, fabs;

  always_comb
  begin
    for (int i = 0; i < NLOG; i++)
      en_v[i] = ivl_r[i] != '0 && sect_r[i] != '0 && !stop_r[i]; // RL6
    take = '0;
    for (int i = NLOG - 1; i >= 0; i--)
      if (pend_r[i] && en_v[i] && state_r == ST_IDLE)
        take = NLOG'(1) << i;
    rsize = 9'(data_r[cur_r]) + 9'(STAMP_BYTES);
    fit = 18'(ofs_r[cur_r]) + 18'(rsize) <= 18'(SECT_BYTES); // RL10
    nsec = (wsec_r[cur_r] + 6'd1 == sect_r[cur_r]) ? 6'h00 : wsec_r[cur_r] + 6'd1; // RL17
    wabs = base[cur_r] + wsec_r[cur_r];
    fabs = base[cur_r] + first_r[cur_r];
    wsec_nxt = wsec_r;
    first_nxt = first_r;
    ofs_nxt = ofs_r;
    stored_nxt = stored_r;
    fseq_nxt = fseq_r;
    scnt_nxt = scnt_r;
    stop_nxt = stop_r;
    cur_nxt = cur_r;
    flash_nxt = flash_r;
    state_nxt = state_r;
    pend_nxt = (pend_r | tick_v) & en_v & ~take;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take != '0)
        begin
          cur_nxt = take[2] ? 2'd2 : (take[1] ? 2'd1 : 2'd0);
          flash_nxt.stamp = i_rtc_stamp; // RL16
          state_nxt = ST_PLACE;
        end
      end
      ST_PLACE:
      begin
        if (fit)
        begin
          flash_nxt.req = 1'b1;
          flash_nxt.erase = 1'b0;
          flash_nxt.log = cur_r;
          flash_nxt.sector = wabs;
          flash_nxt.offset = ofs_r[cur_r][15:0];
          state_nxt = ST_WRITE;
        end
        else if (stored_r[cur_r] != '0 && nsec == first_r[cur_r])
        begin
          if (tmr_r[cur_r])
          begin
            stop_nxt[cur_r] = 1'b1; // RL8
            state_nxt = ST_IDLE;
          end
          else
          begin
            flash_nxt.req = 1'b1; // RL9
            flash_nxt.erase = 1'b1;
            flash_nxt.log = cur_r;
            flash_nxt.sector = fabs;
            flash_nxt.offset = 16'h0000;
            state_nxt = ST_ERASE;
          end
        end
        else
        begin
          wsec_nxt[cur_r] = nsec;
          ofs_nxt[cur_r] = '0;
        end
      end
      ST_ERASE:
      begin
        if (i_flash_ack)
        begin
          flash_nxt.req = 1'b0;
          stored_nxt[cur_r] = stored_r[cur_r] - 20'(scnt_r[fabs]); // RL10
          fseq_nxt[cur_r] = fseq_r[cur_r] + 32'(scnt_r[fabs]);
          scnt_nxt[fabs] = '0;
          first_nxt[cur_r] = (first_r[cur_r] + 6'd1 == sect_r[cur_r]) ? 6'h00
            : first_r[cur_r] + 6'd1; // RL9 RL17
          wsec_nxt[cur_r] = nsec;
          ofs_nxt[cur_r] = '0;
          state_nxt = ST_PLACE;
        end
      end
      ST_WRITE:
      begin
        if (i_flash_ack)
        begin
          flash_nxt.req = 1'b0;
          ofs_nxt[cur_r] = ofs_r[cur_r] + 17'(rsize);
          stored_nxt[cur_r] = stored_r[cur_r] + 20'd1;
          scnt_nxt[wabs] = scnt_r[wabs] + 15'd1;
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (realloc)
    begin
      for (int i = 0; i < NLOG; i++)
      begin
        wsec_nxt[i] = '0;
        first_nxt[i] = '0;
        ofs_nxt[i] = '0;
        stored_nxt[i] = '0;
      end
      for (int s = 0; s < POOL_SECT; s++)
        scnt_nxt[s] = '0;
      stop_nxt = '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      for (int i = 0; i < NLOG; i++)
      begin
        wsec_r[i] <= '0;
        first_r[i] <= '0;
        ofs_r[i] <= '0;
        stored_r[i] <= '0;
        fseq_r[i] <= '0;
      end
      for (int s = 0; s < POOL_SECT; s++)
        scnt_r[s] <= '0;
      stop_r <= '0;
      pend_r <= '0;
      cur_r <= '0;
      flash_r <= '0;
      state_r <= ST_IDLE;
    end
    else
    begin
      wsec_r <= wsec_nxt;
      first_r <= first_nxt;
      ofs_r <= ofs_nxt;
      stored_r <= stored_nxt;
      fseq_r <= fseq_nxt;
      scnt_r <= scnt_nxt;
      stop_r <= stop_nxt;
      pend_r <= pend_nxt;
      cur_r <= cur_nxt;
      flash_r <= flash_nxt;
      state_r <= state_nxt;
    end
  end

  assign o_flash = flash_r;

  // ------------------------------------------------------------
  // Window read and register read-back
  // ------------------------------------------------------------
  logic [1:0] wlog_r, wlog_nxt;
  logic [19:0] wofs_r, wofs_nxt, avail;
  logic [7:0] wcnt_r, wcnt_nxt, quo;
  logic [31:0] wstart_r, wstart_nxt;
  logic wbusy_r, wbusy_nxt, wrng_r, wrng_nxt, dstart, ddone;
  logic [DW-1:0] rdata_r, rdata_nxt;
  logic [1:0] wtype;

  assign wtype = i_bus.wdata[1:0];

  hdl_div #(.W(8)) u_div (
    .i_clock(i_clock),
    .i_reset(i_reset),
    .i_start(dstart),
    .i_num(8'(WIN_BYTES)),
    .i_den(data_r[wtype] + 8'(STAMP_BYTES)),
    .o_done(ddone),
    .o_quo(quo)
  );

  always_comb
  begin
    wlog_nxt = wlog_r;
    wofs_nxt = wofs_r;
    wcnt_nxt = wcnt_r;
    wstart_nxt = wstart_r;
    wbusy_nxt = wbusy_r;
    wrng_nxt = wrng_r;
    dstart = 1'b0;
    avail = stored_r[wlog_r] - wofs_r;
    if (i_bus.wr && i_bus.addr == R_WCTRL && !wbusy_r)
    begin
      wlog_nxt = wtype; // RL13
      wofs_nxt = i_bus.wdata[WC_OFS +: 20];
      wrng_nxt = wtype == 2'd3;
      wcnt_nxt = '0;
      wbusy_nxt = wtype != 2'd3;
      dstart = wtype != 2'd3;
    end
    if (ddone)
    begin
      wbusy_nxt = 1'b0;
      wstart_nxt = fseq_r[wlog_r] + 32'(wofs_r); // RL14
      if (wofs_r >= stored_r[wlog_r])
        wrng_nxt = 1'b1;
      else
        wcnt_nxt = (avail < 20'(quo)) ? avail[7:0] : quo; // RL12
    end
    rdata_nxt = '0;
    if (i_bus.rd && i_bus.addr < R_WCTRL && wl != 2'd3)
    begin
      case (wf)
        R_IVL: rdata_nxt = 32'(ivl_r[wl]);
        R_SECT: rdata_nxt = 32'(sect_r[wl]);
        R_DATA: rdata_nxt = 32'(data_r[wl]);
        R_PARAM: rdata_nxt = 32'(param_r[wl]);
        R_TIMER: rdata_nxt = 32'({end_r[wl], start_r[wl], tmr_r[wl]});
        R_STAT: rdata_nxt = {stop_r[wl], 5'h00, wsec_r[wl], stored_r[wl]};
        R_FIRST: rdata_nxt = fseq_r[wl];
        default: rdata_nxt = '0;
      endcase
    end
    else if (i_bus.rd)
    begin
      case (i_bus.addr)
        R_WCTRL: rdata_nxt = 32'({wofs_r, wlog_r});
        R_WSTART: rdata_nxt = wstart_r;
        R_WCNT: rdata_nxt = 32'({wrng_r, wbusy_r, wcnt_r});
        R_ERR: rdata_nxt = 32'(err_r);
        default: rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      wlog_r <= '0;
      wofs_r <= '0;
      wcnt_r <= '0;
      wstart_r <= '0;
      wbusy_r <= 1'b0;
      wrng_r <= 1'b0;
      rdata_r <= '0;
    end
    else
    begin
      wlog_r <= wlog_nxt;
      wofs_r <= wofs_nxt;
      wcnt_r <= wcnt_nxt;
      wstart_r <= wstart_nxt;
      wbusy_r <= wbusy_nxt;
      wrng_r <= wrng_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence s_erase_done;
    o_flash.req && o_flash.erase && i_flash_ack;
  endsequence
  sequence s_write_req;
    o_flash.req && !o_flash.erase && o_flash.sector == $past(o_flash.sector, 2);
  endsequence

  chk_ivl_range: assert property (ivl_r[0] <= 11'(MAX_IVL) && ivl_r[1] <= 11'(MAX_IVL) // RL4
    && ivl_r[2] <= 11'(MAX_IVL))
    else $error("interval above limit");
  chk_param_range: assert property (param_r[0] <= 7'(MAX_PARAM) // RL2 RL11
    && param_r[1] <= 7'(MAX_PARAM) && param_r[2] <= 7'(MAX_PARAM)
    && data_r[0] <= 8'(MAX_DATA) && data_r[1] <= 8'(MAX_DATA) && data_r[2] <= 8'(MAX_DATA))
    else $error("parameter or data size above limit");
  chk_pool_sum: assert property (8'(sect_r[0]) + 8'(sect_r[1]) + 8'(sect_r[2]) <= 8'(POOL_SECT)) // RL3
    else $error("sector pool overcommitted");
  chk_no_idle_log: assert property ($rose(o_flash.req) |-> ivl_r[o_flash.log] != '0) // RL6
    else $error("disabled log wrote flash");
  chk_timer_keep: assert property (o_flash.req && o_flash.erase |-> !tmr_r[o_flash.log]) // RL8
    else $error("erase on timer log");
  chk_sector_own: assert property (o_flash.req |-> o_flash.sector >= base[o_flash.log]
    && o_flash.sector < base[o_flash.log] + sect_r[o_flash.log]) // RL17
    else $error("sector outside allocation");
  chk_erase_reuse: assert property (s_erase_done |-> ##[2:3] s_write_req) // RL9
    else $error("erased sector not reused");
  chk_rec_fits: assert property (o_flash.req && !o_flash.erase |->
    18'(o_flash.offset) + 18'(rsize) <= 18'(SECT_BYTES)) // RL10
    else $error("record crosses sector");
  chk_win_count: assert property ($fell(wbusy_r) && !wrng_r |->
    16'(wcnt_r) * 16'(9'(data_r[wlog_r]) + 9'(STAMP_BYTES)) <= 16'(WIN_BYTES)) // RL12
    else $error("window count too large");
  chk_win_start: assert property ($fell(wbusy_r) |->
    wstart_r == $past(fseq_r[wlog_r]) + 32'(wofs_r)) // RL14
    else $error("window start wrong");
  chk_stamp_hold: assert property (o_flash.req && $past(o_flash.req) |-> $stable(o_flash.stamp)) // RL16
    else $error("stamp changed during record");
  chk_read_slot: assert property (!$past(i_bus.rd) |-> o_rdata == '0)
    else $error("read data outside its slot");

endmodule
`default_nettype wire

// ==== hdl_flash_model.sv ====
// Flash-side model: acknowledges each logger request after a short random wait.
// Assumes the logger's o_flash struct and the same clock.
`timescale 1ns/1ps
`default_nettype none
module hdl_flash_model
  import hdl_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire hdl_flash_s i_flash,
  output logic o_ack,
  output int o_erases,
  output hdl_flash_s o_last_wr,
  output hdl_flash_s o_last_er
);
  int wait_n;
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_ack <= 1'b0;
      o_erases <= 0;
      wait_n <= 0;
      o_last_wr <= '0;
      o_last_er <= '0;
    end
    else if (o_ack)
      o_ack <= 1'b0;
    else if (i_flash.req && wait_n > 0)
      wait_n <= wait_n - 1;
    else if (i_flash.req)
    begin
      // Prompt and slow answers alternate at random
      o_ack <= 1'b1;
      wait_n <= $urandom_range(0, 3);
      if (i_flash.erase)
      begin
        o_erases <= o_erases + 1;
        o_last_er <= i_flash;
      end
      else
        o_last_wr <= i_flash;
    end
  end
endmodule
`default_nettype wire

// ==== hdl_logger_test.sv ====
// Self-checking bench of the logger: register bus, minute ticks, flash model.
// Assumes hdl_pkg and hdl_flash_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("BAD %s expected %h seen %h", nm, e, g); end end
module hdl_logger_test;
  import hdl_pkg::*;
  typedef struct {string nm; logic [DW-1:0] e; logic [DW-1:0] m;} hdl_note_s;
  logic i_clock, i_reset, tick, ack, rd_d;
  hdl_bus_s bus;
  logic [DW-1:0] rdata, rd_val;
  logic [10:0] day;
  logic [31:0] stamp;
  hdl_flash_s flash, last_wr, last_er;
  int erases, failures, num_checks, ofs, cnt;
  hdl_note_s note_q[$];
  hdl_note_s n;
  int tl[5] = '{0, 0, 1, 2, 3};
  int to[5] = '{1, 3, 0, 0, 0};
  int dsz[3] = '{12, 0, 234};
  int st[3] = '{3, 3, 0};

  hdl_logger i_hdl_logger (.i_clock(i_clock), .i_reset(i_reset), .i_bus(bus), .o_rdata(rdata),
    .i_minute_tick(tick), .i_day_minute(day), .i_rtc_stamp(stamp), .o_flash(flash),
    .i_flash_ack(ack));
  hdl_flash_model i_hdl_flash_model (.i_clock(i_clock), .i_reset(i_reset), .i_flash(flash),
    .o_ack(ack), .o_erases(erases), .o_last_wr(last_wr), .o_last_er(last_er));

  // ------------------------------------------------------------
  // Clock, monitor and closing
  // ------------------------------------------------------------
  initial
  begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    if (rd_d)
    begin
      rd_val = rdata;
      n = note_q.pop_front();
      if (n.m != 0)
        `CHK(n.nm, n.e & n.m, rdata & n.m)
    end
    rd_d <= bus.rd;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    failures++;
    test_done();
  end

  // ------------------------------------------------------------
  // Bus and tick tasks
  // ------------------------------------------------------------
  function automatic logic [AW-1:0] ra(input int l, input logic [2:0] f);
    return AW'(l * 8) + AW'(f);
  endfunction

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_clock);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge i_clock);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e, input logic [DW-1:0] m,
                    input string nm);
    note_q.push_back('{nm, e, m});
    @(posedge i_clock);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
    @(posedge i_clock);
    bus.rd <= 1'b0;
    @(posedge i_clock);
    #1;
  endtask

  task automatic ticks(input int k);
    repeat (k)
    begin
      @(posedge i_clock);
      stamp <= $urandom();
      tick <= 1'b1;
      @(posedge i_clock);
      tick <= 1'b0;
      repeat (17) @(posedge i_clock);
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    i_reset = 1'b1;
    bus = '0;
    tick = 1'b0;
    day = 11'h1f4;
    stamp = '0;
    rd_d = 1'b0;
    void'($urandom(80));
    repeat (12) @(posedge i_clock);
    i_reset <= 1'b0;
    for (int l = 0; l < 3; l++)
    begin
      rd(ra(l, R_IVL), 0, '1, "ivl_rst");
      rd(ra(l, R_SECT), 0, '1, "sect_rst");
    end
    wr(ra(0, R_IVL), 32'(1445 + $urandom_range(0, 599)));
    rd(ra(0, R_IVL), 1444, '1, "ivl_clamp");
    wr(ra(1, R_PARAM), 32'h0000_00c8);
    rd(ra(1, R_PARAM), 117, '1, "param_clamp");
    wr(ra(2, R_DATA), 32'h0000_00ff);
    rd(ra(2, R_DATA), 234, '1, "data_clamp");
    rd(8'h1f, 0, '1, "unmapped");
    wr(ra(0, R_SECT), 30);
    wr(ra(1, R_SECT), 32);
    wr(ra(2, R_SECT), 1);
    rd(ra(2, R_SECT), 1, '1, "sect_sum63");
    wr(ra(2, R_SECT), 2);
    rd(ra(2, R_SECT), 1, '1, "sect_sum64");
    rd(R_ERR, 1, 1, "err_set");
    wr(R_ERR, 0);
    rd(R_ERR, 0, 1, "err_clr");
    wr(ra(0, R_SECT), 2);
    wr(ra(1, R_SECT), 2);
    wr(ra(2, R_SECT), 1);
    // Log 0: snapshot every second tick
    wr(ra(0, R_DATA), 12);
    wr(ra(0, R_IVL), 2);
    ticks(6);
    wr(ra(0, R_IVL), 0);
    rd(ra(0, R_STAT), 3, 32'h000f_ffff, "log0_cnt");
    rd(ra(2, R_STAT), 0, 32'h000f_ffff, "log2_off");
    `CHK("stamp", stamp, last_wr.stamp)
    `CHK("log0_ofs", 16'h0020, last_wr.offset)
    // Log 1: timer window [100,200)
    wr(ra(1, R_DATA), 0);
    wr(ra(1, R_TIMER), 32'(1 | (100 << 1) | (200 << 12)));
    wr(ra(1, R_IVL), 1);
    day <= 11'h032;
    ticks(3);
    day <= 11'h096;
    ticks(3);
    day <= 11'h0c8;
    ticks(2);
    wr(ra(1, R_IVL), 0);
    rd(ra(1, R_STAT), 3, 32'h000f_ffff, "log1_cnt");
    // Window reads over every log type
    for (int i = 0; i < 5; i++)
    begin
      ofs = to[i];
      wr(R_WCTRL, 32'((ofs << 2) | tl[i]));
      rd_val = 32'h0000_0100;
      for (int k = 0; k < 20 && rd_val[8] !== 1'b0; k++)
        rd(R_WCNT, 0, 0, "poll");
      if (tl[i] < 3)
      begin
        cnt = (ofs >= st[tl[i]]) ? 0 : 246 / (dsz[tl[i]] + 4);
        if (cnt > st[tl[i]] - ofs)
          cnt = st[tl[i]] - ofs;
        rd(R_WCNT, 32'(((ofs >= st[tl[i]]) << 9) | cnt), 32'h0000_03ff, "wcnt");
        rd(R_WSTART, 32'(ofs), '1, "wstart");
      end
      else
        rd(R_WCNT, 32'h0000_0200, 32'h0000_0200, "wrange");
    end
    // Read-all of log 0: offset advances by each window's count
    ofs = 0;
    cnt = 1;
    while (cnt != 0 && ofs < 8)
    begin
      wr(R_WCTRL, 32'(ofs << 2));
      rd_val = 32'h0000_0100;
      for (int k = 0; k < 20 && rd_val[8] !== 1'b0; k++)
        rd(R_WCNT, 0, 0, "poll");
      cnt = int'(rd_val[7:0]);
      rd(R_WCNT, 32'(((ofs >= 3) << 9) | ((ofs >= 3) ? 0 : 3 - ofs)), 32'h0000_03ff, "rdall");
      ofs += cnt;
    end
    `CHK("rdall_total", 3, ofs)
    // Log 2: one sector, stop with timer on, recycle with timer off
    wr(ra(2, R_TIMER), 32'(1 | (1439 << 12)));
    wr(ra(2, R_IVL), 1);
    ticks(276);
    rd(ra(2, R_STAT), 32'h8000_0113, 32'h800f_ffff, "log2_stop");
    `CHK("erase_none", 0, erases)
    wr(ra(2, R_SECT), 1);
    wr(ra(2, R_TIMER), 0);
    ticks(276);
    rd(ra(2, R_STAT), 1, 32'h83ff_ffff, "log2_wrap");
    rd(ra(2, R_FIRST), 275, '1, "first_seq");
    `CHK("erase_one", 1, erases)
    `CHK("erase_sect", 6'h04, last_er.sector)
    `CHK("wrap_sect", 6'h04, last_wr.sector)
    `CHK("wrap_ofs", 16'h0000, last_wr.offset)
    test_done();
  end
endmodule
`default_nettype wire
